// ==== rtl/pmagc_pkg.sv ====
// Package of constants, register map and carrier types for the power measurement gain control
package pmagc_pkg;

  // Register indices on the plain register port (word addresses)
  localparam logic [3:0] PMAGC_REG_THRESH    = 4'h0;
  localparam logic [3:0] PMAGC_REG_STEPS     = 4'h1;
  localparam logic [3:0] PMAGC_REG_MEAS      = 4'h2;
  localparam logic [3:0] PMAGC_REG_PERIOD    = 4'h3;
  localparam logic [3:0] PMAGC_REG_LIMITS    = 4'h4;
  localparam logic [3:0] PMAGC_REG_OVERLOAD  = 4'h5;
  localparam logic [3:0] PMAGC_REG_INDEX     = 4'h6;
  localparam logic [3:0] PMAGC_REG_STATUS    = 4'h7;

  // Field positions of the threshold register
  localparam int PMAGC_F_OUP  = 0;
  localparam int PMAGC_F_INUP = 8;
  localparam int PMAGC_F_INLO = 16;
  localparam int PMAGC_F_OLO  = 24;

  // Field positions of the step register
  localparam int PMAGC_F_OATK = 0;
  localparam int PMAGC_F_IATK = 8;
  localparam int PMAGC_F_IREC = 16;
  localparam int PMAGC_F_OREC = 24;

  // Field positions of the measurement, limit and overload registers
  localparam int PMAGC_F_EXP  = 0;
  localparam int PMAGC_F_TAP  = 8;
  localparam int PMAGC_F_DEC  = 16;
  localparam int PMAGC_F_MAX  = 0;
  localparam int PMAGC_F_MIN  = 8;
  localparam int PMAGC_F_OWIN = 0;
  localparam int PMAGC_F_OCNT = 8;

  // Reset values
  localparam logic [3:0]  PMAGC_RST_OUP    = 4'h1;
  localparam logic [6:0]  PMAGC_RST_INUP   = 7'h03;
  localparam logic [6:0]  PMAGC_RST_INLO   = 7'h0C;
  localparam logic [3:0]  PMAGC_RST_OLO    = 4'h4;
  localparam logic [4:0]  PMAGC_RST_OATK   = 5'h04;
  localparam logic [4:0]  PMAGC_RST_IATK   = 5'h02;
  localparam logic [4:0]  PMAGC_RST_IREC   = 5'h02;
  localparam logic [4:0]  PMAGC_RST_OREC   = 5'h04;
  localparam logic [3:0]  PMAGC_RST_EXP    = 4'h8;
  localparam logic [1:0]  PMAGC_RST_TAP    = 2'h2;
  localparam logic [3:0]  PMAGC_RST_DEC    = 4'h2;
  localparam logic [21:0] PMAGC_RST_PERIOD = 22'h007800;
  localparam logic [7:0]  PMAGC_RST_MAX    = 8'hFF;
  localparam logic [7:0]  PMAGC_RST_MIN_RX = 8'hC3;
  localparam logic [7:0]  PMAGC_RST_MIN_OBS = 8'hCB;
  localparam logic [2:0]  PMAGC_RST_OWIN   = 3'h1;
  localparam logic [3:0]  PMAGC_RST_OCNT   = 4'h1;

  // Measurement tap selection
  typedef enum logic [1:0] {
    PMAGC_TAP_OFF  = 2'h0,
    PMAGC_TAP_HB   = 2'h1,
    PMAGC_TAP_FIR  = 2'h2,
    PMAGC_TAP_DC   = 2'h3
  } pmagc_tap_e;

  // Power comparison outcome
  typedef enum logic [2:0] {
    PMAGC_HOLD, PMAGC_ATK_OUT, PMAGC_ATK_IN, PMAGC_REC_IN, PMAGC_REC_OUT
  } pmagc_dec_e;

  // Threshold set carried into the comparator
  typedef struct packed {
    logic [3:0] outer_upper_power_offset;
    logic [6:0] inner_upper_power_level;
    logic [6:0] inner_lower_power_level;
    logic [3:0] outer_lower_power_offset;
  } pmagc_thresh_s;

  // Gain step set
  typedef struct packed {
    logic [4:0] outer_attack_step;
    logic [4:0] inner_attack_step;
    logic [4:0] inner_recovery_step;
    logic [4:0] outer_recovery_step;
  } pmagc_steps_s;

endpackage : pmagc_pkg

// ==== rtl/pmagc_compare.sv ====
// Threshold comparator turning a power level into a gain decision
`timescale 1ns/10ps
`default_nettype none
module pmagc_compare (
  input  wire logic                    clock_i,
  input  wire logic                    reset_i,
  input  wire logic                    valid_i,
  input  wire logic [7:0]              power_db_i,
  input  wire pmagc_pkg::pmagc_thresh_s thresh_i,
  output var  pmagc_pkg::pmagc_dec_e   decision_o,
  output logic                         done_o
);
  import pmagc_pkg::*;

  logic [7:0] outer_up_db;
  logic [7:0] outer_lo_db;
  pmagc_dec_e dec;
  pmagc_dec_e next_dec;
  logic       next_done;

  // Levels are dB below full scale, one dB per LSB; larger value is weaker signal
  always_comb begin
    outer_up_db = {1'b0, thresh_i.inner_upper_power_level} - {4'h0, thresh_i.outer_upper_power_offset};
    outer_lo_db = {1'b0, thresh_i.inner_lower_power_level} + {4'h0, thresh_i.outer_lower_power_offset};
    if (thresh_i.outer_upper_power_offset > thresh_i.inner_upper_power_level) begin
      outer_up_db = 8'h00; // Clamp at full scale
    end
    next_dec  = dec;
    next_done = 1'b0;
    if (valid_i) begin
      next_done = 1'b1;
      // Attack checks come first, outer before inner, so inner upper wins over outer lower when both trip
      if (power_db_i < outer_up_db) begin
        next_dec = PMAGC_ATK_OUT;
      end else if (power_db_i < {1'b0, thresh_i.inner_upper_power_level}) begin
        next_dec = PMAGC_ATK_IN;
      end else if (power_db_i > outer_lo_db) begin
        next_dec = PMAGC_REC_OUT;
      end else if (power_db_i > {1'b0, thresh_i.inner_lower_power_level}) begin
        next_dec = PMAGC_REC_IN;
      end else begin
        next_dec = PMAGC_HOLD;
      end
    end
  end

  // Decision register
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      dec    <= PMAGC_HOLD;
      done_o <= 1'b0;
    end else begin
      dec    <= next_dec;
      done_o <= next_done;
    end
  end
  assign decision_o = dec;

  a_outer_wins: assert property (@(posedge clock_i) disable iff (reset_i)
    valid_i && power_db_i < outer_up_db |=> dec == PMAGC_ATK_OUT)
    else $error("outer attack not chosen");
  a_outer_low: assert property (@(posedge clock_i) disable iff (reset_i)
    valid_i && power_db_i > outer_lo_db && power_db_i >= {1'b0, thresh_i.inner_upper_power_level}
    |=> dec == PMAGC_REC_OUT)
    else $error("outer recovery not chosen");

endmodule : pmagc_compare
`default_nettype wire

// ==== rtl/pmagc_top.sv ====
// Power measurement gain control: detector window, comparator, gain index update and registers
`timescale 1ns/10ps
`default_nettype none
module pmagc_top #(
  parameter logic [7:0] MIN_RESET = pmagc_pkg::PMAGC_RST_MIN_RX,
  parameter int         POW_W     = 8
) (
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_write_i,
  input  wire logic              reg_read_i,
  output logic [31:0]            reg_rdata_o,
  input  wire logic              iq_rate_en_i,
  input  wire logic              fir_in_en_i,
  input  wire logic [POW_W-1:0]  halfband_power_i,
  input  wire logic [POW_W-1:0]  fir_power_i,
  input  wire logic [POW_W-1:0]  dc_power_i,
  input  wire logic              overload_i,
  output logic [7:0]             gain_index_o,
  output logic                   gain_update_o,
  output logic [7:0]             overload_counter_o
);
  import pmagc_pkg::*;

  // Overload window lengths in samples, indexed by window select
  function automatic logic [5:0] win_len(input logic [2:0] sel);
    unique case (sel)
      3'h0: win_len = 6'h01;
      3'h1: win_len = 6'h04;
      3'h2: win_len = 6'h08;
      3'h3: win_len = 6'h0C;
      3'h4: win_len = 6'h10;
      3'h5: win_len = 6'h18;
      3'h6: win_len = 6'h20;
      default: win_len = 6'h20; // Invalid code: longest window
    endcase
  endfunction : win_len

  // Saturating index moves; sums are taken at nine bits so a step near a limit cannot wrap past it
  function automatic logic [7:0] step_down(input logic [7:0] idx, input logic [7:0] lo, input logic [4:0] amt);
    step_down = ({1'b0, idx} < {1'b0, lo} + 9'(amt)) ? lo : idx - 8'(amt);
  endfunction : step_down

  function automatic logic [7:0] step_up(input logic [7:0] idx, input logic [7:0] hi, input logic [4:0] amt);
    step_up = ({1'b0, idx} + 9'(amt) > {1'b0, hi}) ? hi : idx + 8'(amt);
  endfunction : step_up

  // Configuration state
  pmagc_thresh_s thresh, next_thresh;
  pmagc_steps_s  steps, next_steps;
  logic [3:0]    power_window_exponent, next_exp;
  logic [1:0]    power_tap_select, next_tap;
  logic [3:0]    fir_decimation, next_decim;
  logic [21:0]   gain_update_period, next_period;
  logic [7:0]    max_index, next_max;
  logic [7:0]    min_index, next_min;
  logic [2:0]    overload_window_select, next_owin;
  logic [3:0]    overload_instance_count, next_ocnt;
  logic [31:0]   next_rdata;

  // Datapath state
  logic [15:0]   win_cnt, next_win_cnt;
  logic [21:0]   per_cnt, next_per_cnt;
  logic [7:0]    gain_index, next_gain;
  logic [5:0]    ov_win, next_ov_win;
  logic [4:0]    ov_hits, next_ov_hits;
  logic          ov_fired, next_ov_fired;
  logic [7:0]    ov_count, next_ov_count;
  logic          pending, next_pending;
  logic          next_update;
  logic          tap_en;
  logic [POW_W-1:0] tap_power;
  logic          window_done;
  pmagc_dec_e    decision;
  logic          dec_done;

  // Register writes
  always_comb begin
    next_thresh = thresh;
    next_steps  = steps;
    next_exp    = power_window_exponent;
    next_tap    = power_tap_select;
    next_decim  = fir_decimation;
    next_period = gain_update_period;
    next_max    = max_index;
    next_min    = min_index;
    next_owin   = overload_window_select;
    next_ocnt   = overload_instance_count;
    if (reg_write_i) begin
      unique case (reg_addr_i)
        PMAGC_REG_THRESH: begin
          next_thresh.outer_upper_power_offset = reg_wdata_i[PMAGC_F_OUP +: 4];
          next_thresh.inner_upper_power_level  = reg_wdata_i[PMAGC_F_INUP +: 7];
          next_thresh.inner_lower_power_level  = reg_wdata_i[PMAGC_F_INLO +: 7];
          next_thresh.outer_lower_power_offset = reg_wdata_i[PMAGC_F_OLO +: 4];
        end
        PMAGC_REG_STEPS: begin
          next_steps.outer_attack_step   = reg_wdata_i[PMAGC_F_OATK +: 5];
          next_steps.inner_attack_step   = reg_wdata_i[PMAGC_F_IATK +: 5];
          next_steps.inner_recovery_step = reg_wdata_i[PMAGC_F_IREC +: 5];
          next_steps.outer_recovery_step = reg_wdata_i[PMAGC_F_OREC +: 5];
        end
        PMAGC_REG_MEAS: begin
          next_exp   = reg_wdata_i[PMAGC_F_EXP +: 4];
          next_tap   = reg_wdata_i[PMAGC_F_TAP +: 2];
          next_decim = reg_wdata_i[PMAGC_F_DEC +: 4];
        end
        PMAGC_REG_PERIOD: next_period = reg_wdata_i[21:0]; // Software keeps it above the window
        PMAGC_REG_LIMITS: begin
          next_max = reg_wdata_i[PMAGC_F_MAX +: 8];
          next_min = reg_wdata_i[PMAGC_F_MIN +: 8];
        end
        PMAGC_REG_OVERLOAD: begin
          next_owin = reg_wdata_i[PMAGC_F_OWIN +: 3];
          next_ocnt = reg_wdata_i[PMAGC_F_OCNT +: 4];
        end
        default: ; // Read-only and unmapped addresses ignore writes
      endcase
    end
  end

  // Read data, valid the cycle after the read strobe only
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_read_i) begin
      unique case (reg_addr_i)
        PMAGC_REG_THRESH:   next_rdata = {4'h0, thresh.outer_lower_power_offset, 1'b0,
                                          thresh.inner_lower_power_level, 1'b0,
                                          thresh.inner_upper_power_level, 4'h0, thresh.outer_upper_power_offset};
        PMAGC_REG_STEPS:    next_rdata = {3'h0, steps.outer_recovery_step, 3'h0, steps.inner_recovery_step,
                                          3'h0, steps.inner_attack_step, 3'h0, steps.outer_attack_step};
        PMAGC_REG_MEAS:     next_rdata = {12'h000, fir_decimation, 6'h00, power_tap_select,
                                          4'h0, power_window_exponent};
        PMAGC_REG_PERIOD:   next_rdata = {10'h000, gain_update_period};
        PMAGC_REG_LIMITS:   next_rdata = {16'h0000, min_index, max_index};
        PMAGC_REG_OVERLOAD: next_rdata = {20'h00000, overload_instance_count, 5'h00, overload_window_select};
        PMAGC_REG_INDEX:    next_rdata = {24'h000000, gain_index};
        PMAGC_REG_STATUS:   next_rdata = {13'h0000, pending, 2'h0, 5'h00, decision, ov_count};
        default:            next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Configuration and read data registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      thresh <= '{PMAGC_RST_OUP, PMAGC_RST_INUP, PMAGC_RST_INLO, PMAGC_RST_OLO};
      steps  <= '{PMAGC_RST_OATK, PMAGC_RST_IATK, PMAGC_RST_IREC, PMAGC_RST_OREC};
      power_window_exponent   <= PMAGC_RST_EXP;
      power_tap_select        <= PMAGC_RST_TAP;
      fir_decimation          <= PMAGC_RST_DEC;
      gain_update_period      <= PMAGC_RST_PERIOD;
      max_index               <= PMAGC_RST_MAX;
      min_index               <= MIN_RESET;
      overload_window_select  <= PMAGC_RST_OWIN;
      overload_instance_count <= PMAGC_RST_OCNT;
      reg_rdata_o             <= 32'h0000_0000;
    end else begin
      thresh                  <= next_thresh;
      steps                   <= next_steps;
      power_window_exponent   <= next_exp;
      power_tap_select        <= next_tap;
      fir_decimation          <= next_decim;
      gain_update_period      <= next_period;
      max_index               <= next_max;
      min_index               <= next_min;
      overload_window_select  <= next_owin;
      overload_instance_count <= next_ocnt;
      reg_rdata_o             <= next_rdata;
    end
  end

  // Tap decode: halfband tap runs at the FIR input rate, FIR and DC taps at IQ rate, off never runs
  always_comb begin
    unique case (pmagc_tap_e'(power_tap_select))
      PMAGC_TAP_OFF: begin tap_en = 1'b0;          tap_power = '0;               end
      PMAGC_TAP_HB:  begin tap_en = fir_in_en_i;   tap_power = halfband_power_i; end
      PMAGC_TAP_FIR: begin tap_en = iq_rate_en_i;  tap_power = fir_power_i;      end
      PMAGC_TAP_DC:  begin tap_en = iq_rate_en_i;  tap_power = dc_power_i;       end
    endcase
  end
  assign window_done = tap_en && (win_cnt == 16'((32'h1 << power_window_exponent) - 1));

  // Measurement window, update period and gain index
  always_comb begin
    next_win_cnt = win_cnt;
    next_per_cnt = per_cnt;
    next_gain    = gain_index;
    next_pending = pending;
    next_update  = 1'b0;
    if (tap_en) begin
      next_win_cnt = window_done ? 16'h0000 : win_cnt + 16'h0001;
    end
    if (dec_done) begin
      next_pending = 1'b1;
    end
    if (per_cnt >= gain_update_period - 22'h000001) begin
      next_per_cnt = 22'h000000;
      if (pending || dec_done) begin
        next_pending = 1'b0;
        next_update  = 1'b1;
        // Saturating steps within the index limits
        unique case (decision)
          PMAGC_ATK_OUT: next_gain = step_down(gain_index, min_index, steps.outer_attack_step);
          PMAGC_ATK_IN:  next_gain = step_down(gain_index, min_index, steps.inner_attack_step);
          PMAGC_REC_OUT: next_gain = step_up(gain_index, max_index, steps.outer_recovery_step);
          PMAGC_REC_IN:  next_gain = step_up(gain_index, max_index, steps.inner_recovery_step);
          PMAGC_HOLD:    next_gain = gain_index;
        endcase
      end
    end else begin
      next_per_cnt = per_cnt + 22'h000001;
    end
    // Limits moved under a live index, or a step taken from outside them, end back in range
    if (next_gain > max_index) begin
      next_gain = max_index;
    end else if (next_gain < min_index) begin
      next_gain = min_index;
    end
  end

  // Overload detector: one count per window reaching the instance count
  always_comb begin
    next_ov_win   = ov_win;
    next_ov_hits  = ov_hits;
    next_ov_fired = ov_fired;
    next_ov_count = ov_count;
    if (fir_in_en_i) begin
      if (ov_win >= win_len(overload_window_select) - 6'h01) begin
        next_ov_win   = 6'h00;
        next_ov_hits  = 5'h00;
        next_ov_fired = 1'b0;
      end else begin
        next_ov_win = ov_win + 6'h01;
        next_ov_hits = overload_i ? ov_hits + 5'h01 : ov_hits;
      end
      if (!ov_fired && overload_i && (ov_hits + 5'h01 >= {1'b0, overload_instance_count})) begin
        next_ov_count = ov_count + 8'h01;
        next_ov_fired = ov_win < win_len(overload_window_select) - 6'h01; // Window restarts otherwise
      end
    end
  end

  // Datapath registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      win_cnt    <= 16'h0000;
      per_cnt    <= 22'h000000;
      gain_index <= PMAGC_RST_MAX;
      pending    <= 1'b0;
      gain_update_o <= 1'b0;
      ov_win     <= 6'h00;
      ov_hits    <= 5'h00;
      ov_fired   <= 1'b0;
      ov_count   <= 8'h00;
    end else begin
      win_cnt    <= next_win_cnt;
      per_cnt    <= next_per_cnt;
      gain_index <= next_gain;
      pending    <= next_pending;
      gain_update_o <= next_update;
      ov_win     <= next_ov_win;
      ov_hits    <= next_ov_hits;
      ov_fired   <= next_ov_fired;
      ov_count   <= next_ov_count;
    end
  end
  assign gain_index_o       = gain_index;
  assign overload_counter_o = ov_count;

  // Threshold comparator, fed once per finished window
  pmagc_compare u_compare (
    .clock_i    (clock_i),
    .reset_i    (reset_i),
    .valid_i    (window_done),
    .power_db_i (8'(tap_power)),
    .thresh_i   (thresh),
    .decision_o (decision),
    .done_o     (dec_done)
  );

  a_index_range: assert property (@(posedge clock_i) disable iff (reset_i)
    gain_update_o |-> gain_index <= $past(max_index) && gain_index >= $past(min_index))
    else $error("gain index outside limits");
  a_off_no_win: assert property (@(posedge clock_i) disable iff (reset_i)
    power_tap_select == 2'h0 |=> !dec_done)
    else $error("detector ran while disabled");
  a_attack_down: assert property (@(posedge clock_i) disable iff (reset_i)
    next_update && decision == PMAGC_ATK_IN && gain_index >= min_index |=> gain_index <= $past(gain_index))
    else $error("attack raised gain");
  a_recover_up: assert property (@(posedge clock_i) disable iff (reset_i)
    next_update && decision == PMAGC_REC_IN && gain_index <= max_index |=> gain_index >= $past(gain_index))
    else $error("recovery lowered gain");
  a_update_period: assert property (@(posedge clock_i) disable iff (reset_i)
    gain_update_o |-> $past(per_cnt) >= $past(gain_update_period) - 22'h000001)
    else $error("update off period end");
  a_hb_rate: assert property (@(posedge clock_i) disable iff (reset_i)
    power_tap_select == 2'h1 && !fir_in_en_i && win_cnt != 16'h0000 |=> win_cnt == $past(win_cnt))
    else $error("window counted without tap enable");
  a_ov_once: assert property (@(posedge clock_i) disable iff (reset_i)
    ov_fired |=> ov_count == $past(ov_count))
    else $error("overload double counted");

endmodule : pmagc_top
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the power measurement gain control
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pmagc_pkg::*;
  logic        clock_i   = 1'b0;
  logic        reset_i   = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read  = 1'b0;
  logic        iq_en     = 1'b0;
  logic        fir_en    = 1'b0;
  logic [7:0]  hb_p      = 8'h08;
  logic [7:0]  fir_p     = 8'h08;
  logic [7:0]  dc_p      = 8'h08;
  logic        ovl       = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [7:0]  gain_index_o;
  logic        gain_update_o;
  logic [7:0]  overload_counter_o;
  int          num_errors   = 0;
  int          total_checks = 0;
  int          lo = 195;
  int          hi = 255;
  logic [7:0]  cnt;
  // Reset images of registers 0 to 5
  logic [31:0] dflt [6] = '{32'h040C0301, 32'h04020204, 32'h00020208, 32'h00007800, 32'h0000C3FF, 32'h00000101};
  // Threshold boundary powers and the index change each must cause
  int          pw [8] = '{1, 2, 3, 12, 13, 16, 17, 0};
  int          dl [8] = '{-5, -3, 0, 0, 2, 2, 6, -5};

  pmagc_top #(.MIN_RESET(PMAGC_RST_MIN_RX), .POW_W(8)) dut_u (
    .clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_write_i(reg_write), .reg_read_i(reg_read), .reg_rdata_o(reg_rdata_o),
    .iq_rate_en_i(iq_en), .fir_in_en_i(fir_en), .halfband_power_i(hb_p), .fir_power_i(fir_p),
    .dc_power_i(dc_p), .overload_i(ovl), .gain_index_o(gain_index_o), .gain_update_o(gain_update_o),
    .overload_counter_o(overload_counter_o));

  // 25 MHz clock
  initial begin
    forever #20 clock_i = ~clock_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    total_checks++;
    if (seen !== expv) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // One-cycle write strobe; the slave never stalls
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock_i);
    reg_write <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock_i);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock_i);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata_o, e);
  endtask : rd_chk

  // Bounded wait for an applied decision, then let the index settle
  task automatic wait_upd(output bit got);
    got = 1'b0;
    for (int i = 0; i < 140 && !got; i++) begin
      @(posedge clock_i);
      #1;
      got = (gain_update_o === 1'b1);
    end
    repeat (2) @(posedge clock_i);
    #1;
  endtask : wait_upd

  // First update flushes a decision from the old setting; the second is judged
  task automatic step(input int delta, input int exp_got);
    bit got;
    int old;
    int want;
    wait_upd(got);
    old = int'(gain_index_o);
    wait_upd(got);
    want = old + delta;
    if (want > hi) want = hi;
    if (want < lo) want = lo;
    if (exp_got >= 0) check({31'h0, got}, exp_got);
    check({24'h0, gain_index_o}, want);
  endtask : step

  // Watchdog well beyond the expected run of some 3000 cycles
  initial begin
    #1000000;
    num_errors++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    foreach (dflt[i]) rd_chk(4'(i), dflt[i]);
    rd_chk(4'h9, 32'h0);
    wr(PMAGC_REG_INDEX, 32'h00000011);
    rd_chk(PMAGC_REG_INDEX, 32'h000000FF);
    // Distinct steps expose any swap between threshold and step
    wr(PMAGC_REG_STEPS, 32'h06020305);
    wr(PMAGC_REG_PERIOD, 32'd64);
    wr(PMAGC_REG_MEAS, 32'h00020200);
    iq_en  <= 1'b1;
    fir_en <= 1'b1;
    foreach (pw[i]) begin
      fir_p <= 8'(pw[i]);
      step(dl[i], -1);
    end
    // Saturation at narrowed limits
    wr(PMAGC_REG_LIMITS, 32'h0000C8FA);
    hi = 250;
    lo = 200;
    fir_p <= 8'h00;
    repeat (6) step(-5, 1);
    fir_p <= 8'h14;
    repeat (5) step(6, -1);
    fir_p <= 8'h00;
    repeat (2) step(-5, 1);
    // Tap selection and the enable that paces each tap
    hb_p  <= 8'h01;
    fir_p <= 8'h08;
    dc_p  <= 8'h14;
    wr(PMAGC_REG_MEAS, 32'h00020101);
    iq_en <= 1'b0;
    // Halfband samples every other clock: the two-sample window must hold between them
    fork
      step(-5, 1);
      repeat (140) begin
        @(posedge clock_i);
        fir_en <= ~fir_en;
      end
    join
    wr(PMAGC_REG_MEAS, 32'h00020300);
    iq_en  <= 1'b1;
    fir_en <= 1'b0;
    step(6, 1);
    wr(PMAGC_REG_MEAS, 32'h00020000);
    fir_en <= 1'b1;
    step(0, 0);
    wr(PMAGC_REG_MEAS, 32'h00020200);
    fir_p <= 8'h01;
    iq_en <= 1'b0;
    step(0, 0);
    // Overload counting: single-sample window, then one bump per window
    wr(PMAGC_REG_OVERLOAD, 32'h00000000);
    repeat (4) @(posedge clock_i);
    #1;
    cnt = overload_counter_o;
    repeat (3) begin
      @(posedge clock_i);
      ovl <= 1'b1;
      @(posedge clock_i);
      ovl <= 1'b0;
    end
    repeat (6) @(posedge clock_i);
    #1;
    check({24'h0, overload_counter_o}, {24'h0, cnt + 8'h03});
    wr(PMAGC_REG_OVERLOAD, 32'h00000401);
    repeat (8) @(posedge clock_i);
    #1;
    cnt = overload_counter_o;
    // Seven hits cover exactly one whole four-sample window wherever it falls
    @(posedge clock_i);
    ovl <= 1'b1;
    repeat (7) @(posedge clock_i);
    ovl <= 1'b0;
    repeat (10) @(posedge clock_i);
    #1;
    check({24'h0, overload_counter_o}, {24'h0, cnt + 8'h01});
    // Two hits needed: seven hits touch two windows with two or more each, wherever they fall
    wr(PMAGC_REG_OVERLOAD, 32'h00000201);
    repeat (8) @(posedge clock_i);
    #1;
    cnt = overload_counter_o;
    @(posedge clock_i);
    ovl <= 1'b1;
    repeat (7) @(posedge clock_i);
    ovl <= 1'b0;
    repeat (10) @(posedge clock_i);
    #1;
    check({24'h0, overload_counter_o}, {24'h0, cnt + 8'h02});
    give_verdict();
  end
endmodule : tb
`default_nettype wire
